// [verification/xetu_mem_model.sv]
// Data memory port model answering table reads after a set delay.
`timescale 1ns/100ps
`default_nettype none
module xetu_mem_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic mem_rd_req,
    input wire logic [63:0] mem_rd_addr,
    input wire logic [3:0] delay,
    output logic mem_rd_valid,
    output logic [7:0] mem_rd_data
);
    logic pend;
    logic [3:0] cnt;
    logic [7:0] byte_q;
    always @(posedge ref_clk) begin
        mem_rd_valid <= 1'b0;
        // Outside a reply the byte toggles, so a stale value never looks valid.
        mem_rd_data <= ~mem_rd_data;
        if (rst) begin
            pend <= 1'b0;
            mem_rd_data <= 8'h00;
        end else if (mem_rd_req) begin
            pend <= 1'b1;
            cnt <= delay;
            byte_q <= mem_rd_addr[7:0] + 8'h3c;
        end else if (pend && cnt == 4'h0) begin
            pend <= 1'b0;
            mem_rd_valid <= 1'b1;
            mem_rd_data <= byte_q;
        end else if (pend) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule
`default_nettype wire

// [verification/xetu_top_properties.sv]
// Port-level assertions for the execution unit, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module xetu_props
    import xetu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic issue_valid,
    input wire logic two_byte,
    input wire logic [7:0] opcode,
    input wire logic [1:0] operand_size,
    input wire logic [3:0] reg_num,
    input wire logic [63:0] reg_operand,
    input wire logic [63:0] rm_operand,
    input wire logic [63:0] acc_operand,
    input wire logic [63:0] base_operand,
    input wire logic [31:0] immediate,
    input wire logic mem_rd_valid,
    input wire logic [7:0] mem_rd_data,
    input wire logic done,
    input wire logic illegal,
    input wire logic wr_a_en,
    input wire logic [3:0] wr_a_num,
    input wire logic [63:0] wr_a_data,
    input wire logic wr_b_en,
    input wire logic [3:0] wr_b_num,
    input wire logic [63:0] wr_b_data,
    input wire logic mem_wr_en,
    input wire logic mem_rd_req,
    input wire logic [63:0] mem_rd_addr,
    input wire logic flags_wr_en,
    input wire logic [11:0] flags_register
);
    logic wait_mem;
    logic next_wait_mem;
    logic take;
    logic lookup;
    logic [63:0] imm_sx;
    assign take = issue_valid && !wait_mem;
    assign lookup = !two_byte && opcode == OP_LOOKUP;
    assign imm_sx = {{32{immediate[31]}}, immediate};
    // Mirrors the unit's wait for the table read, since issues are ignored meanwhile.
    always_comb begin
        next_wait_mem = mem_rd_valid ? 1'b0 : wait_mem;
        if (take && lookup) begin
            next_wait_mem = 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        wait_mem <= rst ? 1'b0 : next_wait_mem;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    issue_answer_a: assert property (take && !lookup |=> done || illegal)
        else $error("issued operation gave no completion");
    lookup_addr_a: assert property (take && lookup |=> mem_rd_req &&
        mem_rd_addr == $past(base_operand) + ($past(acc_operand) & 64'hff))
        else $error("table read address wrong");
    lookup_load_a: assert property (wait_mem && mem_rd_valid |=> done && wr_a_en &&
        wr_a_num == ACC_REG && wr_a_data[7:0] == $past(mem_rd_data))
        else $error("table byte not loaded into accumulator");
    test_nowrite_a: assert property (take && !two_byte && opcode == OP_TEST |=>
        flags_wr_en && !wr_a_en && !wr_b_en && !mem_wr_en)
        else $error("flag-only and wrote a result");
    flag_clear_a: assert property (flags_wr_en |-> !flags_register[FLAG_CF] &&
        !flags_register[FLAG_OF])
        else $error("carry or overflow left set");
    zero_flag_a: assert property (flags_wr_en && wr_a_en && wr_a_data == ZERO64 |->
        flags_register[FLAG_ZF])
        else $error("zero result without zero flag");
    acc_sext_a: assert property (take && !two_byte && opcode == OP_XOR_ACCW &&
        operand_size == 2'h3 |=> wr_a_en && wr_a_num == ACC_REG &&
        wr_a_data == ($past(acc_operand) ^ $past(imm_sx)))
        else $error("wide accumulator xor wrong");
    xor_reg_a: assert property (take && !two_byte && opcode == OP_XOR_RMW &&
        operand_size == 2'h3 |=> wr_b_en && wr_b_num == $past(reg_num) &&
        wr_b_data == ($past(reg_operand) ^ $past(rm_operand)))
        else $error("register xor destination wrong");
endmodule
bind xetu_top xetu_props u_props (.*);
`default_nettype wire

// [verification/xetu_top_tb.sv]
// Self-checking bench for the execution unit with a reference model.
`timescale 1ns/100ps
`default_nettype none
module xetu_top_tb;
    import xetu_pkg::*;
    logic ref_clk, rst, issue_valid, two_byte, rm_is_mem, mem_rd_valid, spam;
    logic [7:0] opcode, mem_rd_data;
    logic [2:0] modrm_reg_field;
    logic [3:0] reg_num, rm_num, wr_a_num, wr_b_num, delay, e_an, e_bn;
    logic [1:0] operand_size;
    logic [63:0] reg_operand, rm_operand, acc_operand, base_operand, e_a, e_b;
    logic [63:0] wr_a_data, wr_b_data, mem_wr_data, mem_rd_addr;
    logic [31:0] immediate;
    logic [11:0] flags_register_in, flags_register, e_f;
    logic done, illegal, wr_a_en, wr_b_en, mem_wr_en, mem_rd_req, flags_wr_en;
    logic e_ae, e_be, e_me, e_fe, e_il;
    int num_errors = 0, samples_checked = 0, reqs = 0, seed = 32'hbaa5ee7e;
    xetu_top dut (.*);
    xetu_mem_model mem (.*);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (mem_rd_req === 1'b1) begin
            reqs++;
        end
    end
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [95:0] g, input logic [95:0] e);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic model();
        logic [63:0] m, r;
        logic acc, dm, sw;
        logic [1:0] dst;
        m = (64'h1 << (8 << operand_size)) - 64'h1;
        sw = !two_byte && opcode[7:3] == OP_SWAP_ACC[7:3];
        acc = sw || (!two_byte && opcode inside {OP_XOR_ACC8, OP_XOR_ACCW, OP_LOOKUP});
        e_bn = sw ? {reg_num[3], opcode[2:0]} : reg_num;
        e_an = acc ? ACC_REG : rm_num;
        dm = rm_is_mem && !acc;
        e_b = opcode inside {OP_XOR_ACCW, OP_GRP_IMMW} ? {{32{immediate[31]}}, immediate}
            : opcode inside {OP_XOR_ACC8, OP_GRP_IMM8, OP_GRP_IMMS}
            ? {{56{immediate[7]}}, immediate[7:0]} : reg_operand;
        r = ((acc ? acc_operand : rm_operand) ^ e_b) & m;
        {e_be, e_il, dst} = 4'h1;
        e_fe = !two_byte && !sw && !(opcode inside {OP_SWAP8, OP_SWAPW, OP_LOOKUP});
        if (two_byte || sw || opcode inside {OP_SWAP8, OP_SWAPW}) begin
            e_be = 1'b1;
            e_b = (sw ? acc_operand : rm_operand) & m;
            r = (two_byte ? rm_operand + reg_operand : reg_operand) & m;
        end else if (opcode == OP_TEST) begin
            dst = 2'h0;
            r = rm_operand & reg_operand & m;
        end else if (opcode inside {OP_XOR_RM8, OP_XOR_RMW}) begin
            dst = 2'h2;
        end else if (opcode == OP_LOOKUP) begin
            r = {acc_operand[63:8], 8'(base_operand + acc_operand[7:0]) + 8'h3c};
        end else if (opcode[7:4] == 4'h8 && modrm_reg_field != GRP_XOR) begin
            {dst, e_fe, e_il} = 4'h1;
        end
        e_f = flags_register_in;
        e_f[FLAG_CF] = 1'b0;
        e_f[FLAG_OF] = 1'b0;
        e_f[FLAG_ZF] = r == 64'h0;
        e_f[FLAG_SF] = r[(8 << operand_size) - 1];
        e_f[FLAG_PF] = ~^r[7:0];
        e_ae = dst == 2'h1 && !dm;
        e_me = dst == 2'h1 && dm;
        e_be = e_be || dst == 2'h2;
        e_a = r;
        e_b = dst == 2'h2 ? r : e_b;
    endtask
    task automatic issue();
        int n;
        model();
        issue_valid = 1'b1;
        @(negedge ref_clk);
        // Valid stays high after a single-cycle answer, so the next call issues back to back.
        for (n = 0; done !== 1'b1 && illegal !== 1'b1 && n < 20; n++) begin
            issue_valid = spam && n < 2;
            @(negedge ref_clk);
        end
        if (n == 20) begin
            num_errors++;
            print_verdict();
        end
        // An unsupported code still completes, with illegal raised beside done.
        chk({done, illegal, wr_a_en, wr_b_en, mem_wr_en, flags_wr_en},
            {1'b1, e_il, e_ae, e_be, e_me, e_fe});
        if (e_ae) begin
            chk({wr_a_num, wr_a_data}, {e_an, e_a});
        end
        if (e_be) begin
            chk({wr_b_num, wr_b_data}, {e_bn, e_b});
        end
        if (e_me) begin
            chk(mem_wr_data, e_a);
        end
        if (e_fe) begin
            chk(flags_register, e_f);
        end
    endtask
    task automatic rand_ops();
        {reg_operand, rm_operand} = {$random(seed), $random(seed), $random(seed), $random(seed)};
        {acc_operand, base_operand} = {$random(seed), $random(seed), $random(seed), $random(seed)};
        {immediate, flags_register_in, reg_num, rm_num, rm_is_mem} = {$random(seed), 21'($random(seed))};
    endtask
    initial begin
        logic [7:0] xops [9];
        logic [7:0] dops [7];
        xops = '{OP_XOR_ACC8, OP_XOR_ACCW, OP_GRP_IMM8, OP_GRP_IMMW, OP_GRP_IMMS,
            OP_XOR_MR8, OP_XOR_MRW, OP_XOR_RM8, OP_XOR_RMW};
        dops = '{OP_TEST, OP_XADD8, OP_XADDW, OP_SWAP8, OP_SWAPW, OP_GRP_IMM8, OP_SWAP_ACC};
        {rst, issue_valid, spam, two_byte, operand_size, delay} = 10'h200;
        opcode = OP_TEST;
        modrm_reg_field = GRP_XOR;
        rand_ops();
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        for (int k = 0; k < 45; k++) begin
            rand_ops();
            opcode = xops[k < 9 ? k : $unsigned($random(seed)) % 9];
            operand_size = opcode inside {OP_XOR_ACC8, OP_GRP_IMM8, OP_XOR_MR8, OP_XOR_RM8}
                ? 2'h0 : k < 9 ? 2'h3 : 2'h1 + 2'($unsigned($random(seed)) % 3);
            reg_operand = k > 4 && k < 9 ? rm_operand : reg_operand;
            issue();
        end
        for (int j = 0; j < 7; j++) begin
            for (int s = 1; s < 4; s++) begin
                rand_ops();
                two_byte = j inside {1, 2};
                opcode = dops[j] | (j == 6 ? 8'($unsigned($random(seed)) % 8) : 8'h00);
                modrm_reg_field = j == 5 ? 3'h5 : GRP_XOR;
                operand_size = j inside {1, 3, 5} ? 2'h0 : 2'(s);
                issue();
            end
        end
        {two_byte, modrm_reg_field, opcode} = {1'b0, GRP_XOR, OP_LOOKUP};
        for (int d = 0; d < 7; d += 6) begin
            rand_ops();
            {delay, spam, reqs} = {4'(d), 1'b1, 32'h0};
            issue();
            spam = 1'b0;
            chk({reqs, mem_rd_addr}, {32'h1, base_operand + acc_operand[7:0]});
        end
        print_verdict();
    end
endmodule
`default_nettype wire

// [verilog/xetu_alu.sv]
// Combinational add and xor core with width masking and logic flags.
`timescale 1ns/100ps
`default_nettype none
module xetu_alu
    import xetu_pkg::*;
(
    xetu_alu_if.core alu
);
    function automatic logic [63:0] size_mask(input xetu_size_t s);
        case (s)
            XETU_SZ8: size_mask = 64'h00000000000000ff;
            XETU_SZ16: size_mask = 64'h000000000000ffff;
            XETU_SZ32: size_mask = 64'h00000000ffffffff;
            default: size_mask = 64'hffffffffffffffff;
        endcase
    endfunction

    function automatic int sign_pos(input xetu_size_t s);
        case (s)
            XETU_SZ8: sign_pos = 7;
            XETU_SZ16: sign_pos = 15;
            XETU_SZ32: sign_pos = 31;
            default: sign_pos = 63;
        endcase
    endfunction

    logic [63:0] raw;

    always_comb begin
        raw = alu.is_add ? alu.a + alu.b : alu.a ^ alu.b;
        alu.result = raw & size_mask(alu.size);
        alu.flags_out = alu.flags_in;
        // The adder leaves flags alone here; only the logic path redefines them.
        if (!alu.is_add) begin
            alu.flags_out[FLAG_CF] = 1'b0;
            alu.flags_out[FLAG_OF] = 1'b0;
            alu.flags_out[FLAG_ZF] = (alu.result == ZERO64);
            alu.flags_out[FLAG_SF] = alu.result[sign_pos(alu.size)];
            alu.flags_out[FLAG_PF] = ~^alu.result[7:0];
        end
    end
endmodule
`default_nettype wire

// [verilog/xetu_alu_if.sv]
// Interface between the unit's control and its arithmetic core.
`timescale 1ns/100ps
`default_nettype none
interface xetu_alu_if;
    import xetu_pkg::*;
    logic [63:0] a;
    logic [63:0] b;
    logic is_add;
    xetu_size_t size;
    logic [63:0] result;
    logic [11:0] flags_in;
    logic [11:0] flags_out;
    modport ctrl (output a, output b, output is_add, output size, output flags_in,
                  input result, input flags_out);
    modport core (input a, input b, input is_add, input size, input flags_in,
                  output result, output flags_out);
endinterface
`default_nettype wire

// [verilog/xetu_pkg.sv]
// Package of constants and types for the exchange, translate and xor execution unit.
package xetu_pkg;
    localparam logic [7:0] OP_TEST = 8'h85;
    localparam logic [7:0] OP_XADD8 = 8'hc0;
    localparam logic [7:0] OP_XADDW = 8'hc1;
    localparam logic [7:0] OP_SWAP_ACC = 8'h90;
    localparam logic [7:0] OP_SWAP8 = 8'h86;
    localparam logic [7:0] OP_SWAPW = 8'h87;
    localparam logic [7:0] OP_LOOKUP = 8'hd7;
    localparam logic [7:0] OP_XOR_ACC8 = 8'h34;
    localparam logic [7:0] OP_XOR_ACCW = 8'h35;
    localparam logic [7:0] OP_GRP_IMM8 = 8'h80;
    localparam logic [7:0] OP_GRP_IMMW = 8'h81;
    localparam logic [7:0] OP_GRP_IMMS = 8'h83;
    localparam logic [7:0] OP_XOR_MR8 = 8'h30;
    localparam logic [7:0] OP_XOR_MRW = 8'h31;
    localparam logic [7:0] OP_XOR_RM8 = 8'h32;
    localparam logic [7:0] OP_XOR_RMW = 8'h33;
    localparam logic [2:0] GRP_XOR = 3'h6;
    localparam logic [3:0] ACC_REG = 4'h0;
    localparam logic [3:0] BASE_REG = 4'h3;
    localparam int FLAG_CF = 0;
    localparam int FLAG_PF = 2;
    localparam int FLAG_ZF = 6;
    localparam int FLAG_SF = 7;
    localparam int FLAG_OF = 11;
    localparam logic [2:0] FLAG_MASK_LOGIC = 3'h0;
    localparam logic [63:0] ZERO64 = 64'h0;
    typedef enum logic [1:0] {XETU_SZ8, XETU_SZ16, XETU_SZ32, XETU_SZ64} xetu_size_t;
    typedef enum {XETU_IDLE, XETU_WAIT_MEM} xetu_state_t;
endpackage

// [verilog/xetu_top.sv]
// Execution unit for test, exchange, exchange-add, table lookup and xor operations.
`timescale 1ns/100ps
`default_nettype none
module xetu_top
    import xetu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic issue_valid,
    input wire logic two_byte,
    input wire logic [7:0] opcode,
    input wire logic [2:0] modrm_reg_field,
    input wire logic [3:0] reg_num,
    input wire logic [3:0] rm_num,
    input wire logic rm_is_mem,
    input wire logic [1:0] operand_size,
    input wire logic [63:0] reg_operand,
    input wire logic [63:0] rm_operand,
    input wire logic [63:0] acc_operand,
    input wire logic [63:0] base_operand,
    input wire logic [31:0] immediate,
    input wire logic [11:0] flags_register_in,
    input wire logic mem_rd_valid,
    input wire logic [7:0] mem_rd_data,
    output logic done,
    output logic illegal,
    output logic wr_a_en,
    output logic [3:0] wr_a_num,
    output logic [63:0] wr_a_data,
    output logic wr_b_en,
    output logic [3:0] wr_b_num,
    output logic [63:0] wr_b_data,
    output logic mem_wr_en,
    output logic [63:0] mem_wr_data,
    output logic mem_rd_req,
    output logic [63:0] mem_rd_addr,
    output logic flags_wr_en,
    output logic [11:0] flags_register
);
    xetu_alu_if alu_bus();

    xetu_alu u_alu (
        .alu(alu_bus)
    );

    function automatic logic [63:0] sext8(input logic [7:0] v);
        sext8 = {{56{v[7]}}, v};
    endfunction

    function automatic logic [63:0] sext32(input logic [31:0] v);
        sext32 = {{32{v[31]}}, v};
    endfunction

    // Swaps bypass the core, so they mask to the operand width here instead.
    function automatic logic [63:0] width_mask(input xetu_size_t s);
        case (s)
            XETU_SZ8: width_mask = 64'h00000000000000ff;
            XETU_SZ16: width_mask = 64'h000000000000ffff;
            XETU_SZ32: width_mask = 64'h00000000ffffffff;
            default: width_mask = 64'hffffffffffffffff;
        endcase
    endfunction

    xetu_state_t state, next_state;
    logic next_done, next_illegal, next_wr_a_en, next_wr_b_en, next_mem_wr_en;
    logic next_mem_rd_req, next_flags_wr_en;
    logic [3:0] next_wr_a_num, next_wr_b_num;
    logic [63:0] next_wr_a_data, next_wr_b_data, next_mem_wr_data, next_mem_rd_addr;
    logic [11:0] next_flags_register;
    xetu_size_t wsize;
    logic [63:0] wide_imm;

    always_comb begin
        wsize = xetu_size_t'(operand_size);
        wide_imm = (wsize == XETU_SZ16) ? {48'h0, immediate[15:0]} : sext32(immediate);
        alu_bus.a = rm_operand;
        alu_bus.b = reg_operand;
        alu_bus.is_add = 1'b0;
        alu_bus.size = wsize;
        alu_bus.flags_in = flags_register_in;
        if (two_byte) begin
            alu_bus.is_add = 1'b1;
            alu_bus.size = (opcode == OP_XADD8) ? XETU_SZ8 : wsize;
        end else if (opcode == OP_XOR_ACC8 || opcode == OP_XOR_ACCW) begin
            alu_bus.a = acc_operand;
            alu_bus.b = (opcode == OP_XOR_ACC8) ? {56'h0, immediate[7:0]} : wide_imm;
            alu_bus.size = (opcode == OP_XOR_ACC8) ? XETU_SZ8 : wsize;
        end else if (opcode == OP_GRP_IMM8) begin
            alu_bus.b = {56'h0, immediate[7:0]};
            alu_bus.size = XETU_SZ8;
        end else if (opcode == OP_GRP_IMMW) begin
            alu_bus.b = wide_imm;
        end else if (opcode == OP_GRP_IMMS) begin
            alu_bus.b = sext8(immediate[7:0]);
        end else if (opcode == OP_XOR_MR8 || opcode == OP_XOR_RM8) begin
            alu_bus.size = XETU_SZ8;
        end else if (opcode == OP_TEST) begin
            // The core only adds or xors; xor with zero passes the AND through for flags.
            alu_bus.a = rm_operand & reg_operand;
            alu_bus.b = ZERO64;
        end else if (opcode == OP_SWAP8) begin
            alu_bus.size = XETU_SZ8;
        end
    end

    always_comb begin
        next_state = state;
        next_done = 1'b0;
        next_illegal = 1'b0;
        next_wr_a_en = 1'b0;
        next_wr_a_num = wr_a_num;
        next_wr_a_data = wr_a_data;
        next_wr_b_en = 1'b0;
        next_wr_b_num = wr_b_num;
        next_wr_b_data = wr_b_data;
        next_mem_wr_en = 1'b0;
        next_mem_wr_data = mem_wr_data;
        next_mem_rd_req = 1'b0;
        next_mem_rd_addr = mem_rd_addr;
        next_flags_wr_en = 1'b0;
        next_flags_register = flags_register;
        case (state)
            XETU_IDLE: begin
                if (issue_valid) begin
                    next_done = 1'b1;
                    // Port A is the reg/mem destination; port B the ModRM reg register.
                    next_wr_a_num = rm_num;
                    next_wr_b_num = reg_num;
                    if (two_byte) begin
                        if (opcode == OP_XADD8 || opcode == OP_XADDW) begin
                            next_wr_b_en = 1'b1;
                            next_wr_b_data = rm_operand & width_mask(alu_bus.size);
                            next_wr_a_en = !rm_is_mem;
                            next_mem_wr_en = rm_is_mem;
                            next_wr_a_data = alu_bus.result;
                            next_mem_wr_data = alu_bus.result;
                        end else begin
                            next_illegal = 1'b1;
                        end
                    end else if (opcode == OP_TEST) begin
                        next_flags_wr_en = 1'b1;
                        next_flags_register = alu_bus.flags_out;
                        // The AND result is discarded, so no write port fires.
                    end else if (opcode[7:3] == OP_SWAP_ACC[7:3]) begin
                        next_wr_a_en = 1'b1;
                        next_wr_a_num = ACC_REG;
                        next_wr_a_data = reg_operand & width_mask(alu_bus.size);
                        next_wr_b_en = 1'b1;
                        next_wr_b_num = {reg_num[3], opcode[2:0]};
                        next_wr_b_data = acc_operand & width_mask(alu_bus.size);
                    end else if (opcode == OP_SWAP8 || opcode == OP_SWAPW) begin
                        // Both mnemonic orders decode to this same path.
                        next_wr_a_en = !rm_is_mem;
                        next_mem_wr_en = rm_is_mem;
                        next_wr_a_data = reg_operand & width_mask(alu_bus.size);
                        next_mem_wr_data = reg_operand & width_mask(alu_bus.size);
                        next_wr_b_en = 1'b1;
                        next_wr_b_data = rm_operand & width_mask(alu_bus.size);
                    end else if (opcode == OP_LOOKUP) begin
                        next_done = 1'b0;
                        next_mem_rd_req = 1'b1;
                        next_mem_rd_addr = base_operand + {56'h0, acc_operand[7:0]};
                        next_state = XETU_WAIT_MEM;
                    end else if (opcode == OP_XOR_ACC8 || opcode == OP_XOR_ACCW) begin
                        next_wr_a_en = 1'b1;
                        next_wr_a_num = ACC_REG;
                        next_wr_a_data = alu_bus.result;
                        next_flags_wr_en = 1'b1;
                        next_flags_register = alu_bus.flags_out;
                    end else if (((opcode == OP_GRP_IMM8 || opcode == OP_GRP_IMMW ||
                                   opcode == OP_GRP_IMMS) && modrm_reg_field == GRP_XOR) ||
                                 opcode == OP_XOR_MR8 || opcode == OP_XOR_MRW) begin
                        next_wr_a_en = !rm_is_mem;
                        next_mem_wr_en = rm_is_mem;
                        next_wr_a_data = alu_bus.result;
                        next_mem_wr_data = alu_bus.result;
                        next_flags_wr_en = 1'b1;
                        next_flags_register = alu_bus.flags_out;
                    end else if (opcode == OP_XOR_RM8 || opcode == OP_XOR_RMW) begin
                        next_wr_b_en = 1'b1;
                        next_wr_b_data = alu_bus.result;
                        next_flags_wr_en = 1'b1;
                        next_flags_register = alu_bus.flags_out;
                    end else begin
                        next_illegal = 1'b1;
                    end
                end
            end
            XETU_WAIT_MEM: begin
                // New issues are not taken while the lookup read is outstanding.
                if (mem_rd_valid) begin
                    next_wr_a_en = 1'b1;
                    next_wr_a_num = ACC_REG;
                    next_wr_a_data = {acc_operand[63:8], mem_rd_data};
                    next_done = 1'b1;
                    next_state = XETU_IDLE;
                end
            end
            default: next_state = XETU_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= XETU_IDLE;
            done <= 1'b0;
            illegal <= 1'b0;
            wr_a_en <= 1'b0;
            wr_a_num <= ACC_REG;
            wr_a_data <= ZERO64;
            wr_b_en <= 1'b0;
            wr_b_num <= ACC_REG;
            wr_b_data <= ZERO64;
            mem_wr_en <= 1'b0;
            mem_wr_data <= ZERO64;
            mem_rd_req <= 1'b0;
            mem_rd_addr <= ZERO64;
            flags_wr_en <= 1'b0;
            flags_register <= 12'h000;
        end else begin
            state <= next_state;
            done <= next_done;
            illegal <= next_illegal;
            wr_a_en <= next_wr_a_en;
            wr_a_num <= next_wr_a_num;
            wr_a_data <= next_wr_a_data;
            wr_b_en <= next_wr_b_en;
            wr_b_num <= next_wr_b_num;
            wr_b_data <= next_wr_b_data;
            mem_wr_en <= next_mem_wr_en;
            mem_wr_data <= next_mem_wr_data;
            mem_rd_req <= next_mem_rd_req;
            mem_rd_addr <= next_mem_rd_addr;
            flags_wr_en <= next_flags_wr_en;
            flags_register <= next_flags_register;
        end
    end
endmodule
`default_nettype wire
